// >>> logic/ugsf_pkg.sv
package ugsf_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [11:0] OFS_STATUS = 12'h804;
   localparam logic [11:0] OFS_CLEAR = 12'h808;
   localparam logic [11:0] OFS_SET = 12'h80C;
   localparam logic [11:0] OFS_VERSION = 12'h818;
   localparam logic [11:0] OFS_FEATURES = 12'h81C;
   localparam logic [11:0] OFS_ADDR_SIZE = 12'h820;

   // ----------------------------------------
   // Status field positions
   // ----------------------------------------
   localparam int BIT_IDPIN_EDGE = 0;
   localparam int BIT_VBUS_EDGE = 1;
   localparam int BIT_VBUS_ERROR = 3;
   localparam int BIT_BCONN_ERROR = 4;
   localparam int BIT_ROLE_SWAP = 5;
   localparam int BIT_SUSPEND_TIMEOUT = 7;
   localparam int BIT_SUPPLY_REQUEST = 9;
   localparam int BIT_IDPIN_LEVEL = 10;
   localparam int BIT_VBUS_LEVEL = 11;
   localparam int BIT_SPEED_LO = 12;

   // ----------------------------------------
   // Features and version field positions
   // ----------------------------------------
   localparam int FEAT_ENDPOINT_LO = 0;
   localparam int FEAT_CHANNEL_LO = 4;
   localparam int FEAT_DMA_WIDTH = 7;
   localparam int FEAT_DEPTH_LO = 8;
   localparam int FEAT_SIZE_CODE_LO = 12;
   localparam int FEAT_BYTE_WRITE = 15;
   localparam int VER_VERSION_LO = 0;
   localparam int VER_VARIANT_LO = 16;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [31:0] STATUS_RESET = 32'h0000_0400;
   localparam logic VBUS_LEVEL_RESET = 1'h0;
   localparam logic IDPIN_LEVEL_RESET = 1'h1;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : ugsf_pkg

// >>> logic/ugsf_edge_detect.sv
`timescale 1ns/1ps
// Level tracker with a both-edge pulse
module ugsf_edge_detect #(
   parameter logic RESET_LEVEL = 1'b0
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic level_in,
   output logic level_q,
   output logic edge_pulse
);
   logic level_d;

   // Remember last level
   always_comb begin
      level_d = level_in;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         level_q <= RESET_LEVEL;
      end else begin
         level_q <= level_d;
      end
   end

   // Either direction counts
   assign edge_pulse = level_in ^ level_q;
endmodule : ugsf_edge_detect

// >>> logic/ugsf_capability.sv
`timescale 1ns/1ps
// Build-time capability words
module ugsf_capability #(
   parameter int VERSION = 12'h100,
   parameter int VARIANT = 4'h0,
   parameter bit BYTE_WRITE = 1'b1,
   parameter int SIZE_CODE = 3,
   parameter int DMA_FIFO_DEPTH = 16,
   parameter bit DMA_WIDE = 1'b0,
   parameter int DMA_CHANNELS = 7,
   parameter int ENDPOINTS = 7,
   parameter int ADDR_SIZE = 32'h0000_1000
) (
   output logic [31:0] version_word,
   output logic [31:0] features_word,
   output logic [31:0] addr_size_word
);
   // Refuse values the fields cannot hold
   if (SIZE_CODE < 0 || SIZE_CODE > 7 || DMA_FIFO_DEPTH < 1 || DMA_FIFO_DEPTH > 16 ||
       DMA_CHANNELS < 1 || DMA_CHANNELS > 7 || ENDPOINTS < 1 || ENDPOINTS > 16 ||
       VERSION < 0 || VERSION > 4095 || VARIANT < 0 || VARIANT > 15) begin : g_bad_param
      $error("ugsf_capability: parameter out of range");
   end

   // Count of 1..16 into four bits, 16 as zero
   function automatic logic [3:0] ugsf_count4(input int n);
      ugsf_count4 = (n == 16) ? 4'h0 : n[3:0];
   endfunction : ugsf_count4

   // Assemble read-only words
   always_comb begin
      version_word = ugsf_pkg::READ_ZERO;
      version_word[ugsf_pkg::VER_VERSION_LO +: 12] = VERSION[11:0];
      version_word[ugsf_pkg::VER_VARIANT_LO +: 4] = VARIANT[3:0];
      features_word = ugsf_pkg::READ_ZERO;
      features_word[ugsf_pkg::FEAT_BYTE_WRITE] = BYTE_WRITE;
      features_word[ugsf_pkg::FEAT_SIZE_CODE_LO +: 3] = SIZE_CODE[2:0];
      features_word[ugsf_pkg::FEAT_DEPTH_LO +: 4] = ugsf_count4(DMA_FIFO_DEPTH);
      features_word[ugsf_pkg::FEAT_DMA_WIDTH] = DMA_WIDE;
      features_word[ugsf_pkg::FEAT_CHANNEL_LO +: 3] = DMA_CHANNELS[2:0];
      features_word[ugsf_pkg::FEAT_ENDPOINT_LO +: 4] = ugsf_count4(ENDPOINTS);
      addr_size_word = ADDR_SIZE[31:0];
   end
endmodule : ugsf_capability

// >>> logic/ugsf_status_bank.sv
`timescale 1ns/1ps
// Function
// - VBus drop sets error flag; interrupt when flag and its enable are one.
// - Error flag rises on VBus problem even with hardware supply control off.
// - Error flag clears only by writing one to its clear bit.
// - Either VBus edge sets transition flag; enabled flag interrupts; clear bit clears.
// - Either id pin edge sets id flag; enabled flag interrupts; clear bit clears.
// - Edge detectors keep running while controller clock is frozen.
// - Clear register: ones clear status bits 9,7,5,4,3,1,0; zeros do nothing.
// - Set register: ones force status bits 9,7,5,4,3,1,0 to one; zeros do nothing.
// - Clear and set registers always read zero.
// - Version register holds version bits 11:0 and variant bits 19:16.
// - Features bit 15 tells native byte-write packet memory.
// - Features bits 14:12 encode packet memory size, doubling from 256 bytes.
// - Features bits 11:8 give DMA FIFO depth, zero meaning 16.
// - Features bit 7 one means 24-bit DMA length counter.
// - Features bits 6:4 give DMA channel count, 1 to 7.
// - Features bits 3:0 give endpoint count, zero meaning 16.
// - Address size register reports register space size.
// - Supply request set by set bit, cleared by clear bit or error with hardware control.
// - Status register readable, resets to only bit 10 set.
module ugsf_status_bank #(
   parameter int VERSION = 12'h100,
   parameter int VARIANT = 4'h0,
   parameter bit BYTE_WRITE = 1'b1,
   parameter int SIZE_CODE = 3,
   parameter int DMA_FIFO_DEPTH = 16,
   parameter bit DMA_WIDE = 1'b0,
   parameter int DMA_CHANNELS = 7,
   parameter int ENDPOINTS = 7,
   parameter int ADDR_SIZE = 32'h0000_1000
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic vbus_level,
   input wire logic role_id_input,
   input wire logic vbus_drop,
   input wire logic suspend_timeout_event,
   input wire logic role_swap_event,
   input wire logic bconn_error_event,
   input wire logic [1:0] speed_status,
   input wire logic vbus_output_hw_control_off,
   input wire logic vbus_error_irq_enable,
   input wire logic vbus_edge_irq_enable,
   input wire logic idpin_edge_irq_enable,
   input wire logic suspend_timeout_irq_enable,
   input wire logic role_swap_irq_enable,
   input wire logic bconn_error_irq_enable,
   output logic usb_irq,
   output logic vbus_supply_request,
   output logic [31:0] general_status_register
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic vbus_level_q;
   logic vbus_edge;
   logic idpin_level_q;
   logic idpin_edge;
   logic [31:0] version_word;
   logic [31:0] features_word;
   logic [31:0] addr_size_word;
   logic clr_wr;
   logic set_wr;
   logic [31:0] clr_bits;
   logic [31:0] set_bits;
   logic vbus_error_flag_q, vbus_error_flag_d;
   logic vbus_edge_flag_q, vbus_edge_flag_d;
   logic idpin_edge_flag_q, idpin_edge_flag_d;
   logic suspend_timeout_flag_q, suspend_timeout_flag_d;
   logic role_swap_flag_q, role_swap_flag_d;
   logic bconn_error_flag_q, bconn_error_flag_d;
   logic supply_request_q, supply_request_d;
   logic irq_q, irq_d;
   logic [31:0] status_q, status_d;
   logic [31:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;

   // Sticky flag update, set winning over clear
   function automatic logic ugsf_sticky(input logic cur, input logic set, input logic clr);
      ugsf_sticky = set | (cur & ~clr);
   endfunction : ugsf_sticky

   // ----------------------------------------
   // Pin edge detectors
   // ----------------------------------------
   // Run on the free clock, untouched by freeze
   ugsf_edge_detect #(
      .RESET_LEVEL(ugsf_pkg::VBUS_LEVEL_RESET)
   ) u_vbus_edge (
      .clk_sys(clk_sys),
      .reset(reset),
      .level_in(vbus_level),
      .level_q(vbus_level_q),
      .edge_pulse(vbus_edge)
   );

   ugsf_edge_detect #(
      .RESET_LEVEL(ugsf_pkg::IDPIN_LEVEL_RESET)
   ) u_idpin_edge (
      .clk_sys(clk_sys),
      .reset(reset),
      .level_in(role_id_input),
      .level_q(idpin_level_q),
      .edge_pulse(idpin_edge)
   );

   // ----------------------------------------
   // Capability constants
   // ----------------------------------------
   ugsf_capability #(
      .VERSION(VERSION),
      .VARIANT(VARIANT),
      .BYTE_WRITE(BYTE_WRITE),
      .SIZE_CODE(SIZE_CODE),
      .DMA_FIFO_DEPTH(DMA_FIFO_DEPTH),
      .DMA_WIDE(DMA_WIDE),
      .DMA_CHANNELS(DMA_CHANNELS),
      .ENDPOINTS(ENDPOINTS),
      .ADDR_SIZE(ADDR_SIZE)
   ) u_capability (
      .version_word(version_word),
      .features_word(features_word),
      .addr_size_word(addr_size_word)
   );

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   // Ones only act; writes elsewhere ignored
   assign clr_wr = reg_wr && (reg_addr == ugsf_pkg::OFS_CLEAR);
   assign set_wr = reg_wr && (reg_addr == ugsf_pkg::OFS_SET);
   assign clr_bits = clr_wr ? reg_wdata : ugsf_pkg::READ_ZERO;
   assign set_bits = set_wr ? reg_wdata : ugsf_pkg::READ_ZERO;

   // ----------------------------------------
   // Status flags
   // ----------------------------------------
   // Next flag values and interrupt request
   always_comb begin
      // Error flag rises regardless of hardware control setting
      vbus_error_flag_d = ugsf_sticky(vbus_error_flag_q,
         vbus_drop | set_bits[ugsf_pkg::BIT_VBUS_ERROR],
         clr_bits[ugsf_pkg::BIT_VBUS_ERROR]);
      vbus_edge_flag_d = ugsf_sticky(vbus_edge_flag_q,
         vbus_edge | set_bits[ugsf_pkg::BIT_VBUS_EDGE],
         clr_bits[ugsf_pkg::BIT_VBUS_EDGE]);
      idpin_edge_flag_d = ugsf_sticky(idpin_edge_flag_q,
         idpin_edge | set_bits[ugsf_pkg::BIT_IDPIN_EDGE],
         clr_bits[ugsf_pkg::BIT_IDPIN_EDGE]);
      suspend_timeout_flag_d = ugsf_sticky(suspend_timeout_flag_q,
         suspend_timeout_event | set_bits[ugsf_pkg::BIT_SUSPEND_TIMEOUT],
         clr_bits[ugsf_pkg::BIT_SUSPEND_TIMEOUT]);
      role_swap_flag_d = ugsf_sticky(role_swap_flag_q,
         role_swap_event | set_bits[ugsf_pkg::BIT_ROLE_SWAP],
         clr_bits[ugsf_pkg::BIT_ROLE_SWAP]);
      bconn_error_flag_d = ugsf_sticky(bconn_error_flag_q,
         bconn_error_event | set_bits[ugsf_pkg::BIT_BCONN_ERROR],
         clr_bits[ugsf_pkg::BIT_BCONN_ERROR]);
      // Supply request drops on error only under hardware control
      supply_request_d = ugsf_sticky(supply_request_q,
         set_bits[ugsf_pkg::BIT_SUPPLY_REQUEST],
         clr_bits[ugsf_pkg::BIT_SUPPLY_REQUEST] |
         (vbus_drop & ~vbus_output_hw_control_off));
      // Interrupt from next flag values
      irq_d = (vbus_error_flag_d & vbus_error_irq_enable) |
         (vbus_edge_flag_d & vbus_edge_irq_enable) |
         (idpin_edge_flag_d & idpin_edge_irq_enable) |
         (suspend_timeout_flag_d & suspend_timeout_irq_enable) |
         (role_swap_flag_d & role_swap_irq_enable) |
         (bconn_error_flag_d & bconn_error_irq_enable);
      // Status word as software sees it
      status_d = ugsf_pkg::READ_ZERO;
      status_d[ugsf_pkg::BIT_IDPIN_EDGE] = idpin_edge_flag_d;
      status_d[ugsf_pkg::BIT_VBUS_EDGE] = vbus_edge_flag_d;
      status_d[ugsf_pkg::BIT_VBUS_ERROR] = vbus_error_flag_d;
      status_d[ugsf_pkg::BIT_BCONN_ERROR] = bconn_error_flag_d;
      status_d[ugsf_pkg::BIT_ROLE_SWAP] = role_swap_flag_d;
      status_d[ugsf_pkg::BIT_SUSPEND_TIMEOUT] = suspend_timeout_flag_d;
      status_d[ugsf_pkg::BIT_SUPPLY_REQUEST] = supply_request_d;
      status_d[ugsf_pkg::BIT_IDPIN_LEVEL] = role_id_input;
      status_d[ugsf_pkg::BIT_VBUS_LEVEL] = vbus_level;
      status_d[ugsf_pkg::BIT_SPEED_LO +: 2] = speed_status;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         vbus_error_flag_q <= 1'b0;
         vbus_edge_flag_q <= 1'b0;
         idpin_edge_flag_q <= 1'b0;
         suspend_timeout_flag_q <= 1'b0;
         role_swap_flag_q <= 1'b0;
         bconn_error_flag_q <= 1'b0;
         supply_request_q <= 1'b0;
         irq_q <= 1'b0;
         status_q <= ugsf_pkg::STATUS_RESET;
      end else begin
         vbus_error_flag_q <= vbus_error_flag_d;
         vbus_edge_flag_q <= vbus_edge_flag_d;
         idpin_edge_flag_q <= idpin_edge_flag_d;
         suspend_timeout_flag_q <= suspend_timeout_flag_d;
         role_swap_flag_q <= role_swap_flag_d;
         bconn_error_flag_q <= bconn_error_flag_d;
         supply_request_q <= supply_request_d;
         irq_q <= irq_d;
         status_q <= status_d;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Registered read data, zero for write-only and unmapped
   always_comb begin
      rvalid_d = reg_rd;
      rdata_d = ugsf_pkg::READ_ZERO;
      if (reg_rd) begin
         unique case (reg_addr)
            ugsf_pkg::OFS_STATUS: rdata_d = status_q;
            ugsf_pkg::OFS_VERSION: rdata_d = version_word;
            ugsf_pkg::OFS_FEATURES: rdata_d = features_word;
            ugsf_pkg::OFS_ADDR_SIZE: rdata_d = addr_size_word;
            default: rdata_d = ugsf_pkg::READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rdata_q <= ugsf_pkg::READ_ZERO;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;
   assign usb_irq = irq_q;
   assign vbus_supply_request = supply_request_q;
   assign general_status_register = status_q;
endmodule : ugsf_status_bank

// >>> verif/ugsf_status_bank_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Status bank checker
// ----------------------------------------
module ugsf_status_bank_assertions (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic vbus_level,
   input wire logic role_id_input,
   input wire logic vbus_drop,
   input wire logic role_swap_event,
   input wire logic vbus_output_hw_control_off,
   input wire logic vbus_error_irq_enable,
   input wire logic vbus_edge_irq_enable,
   input wire logic usb_irq,
   input wire logic vbus_supply_request,
   input wire logic [31:0] general_status_register
);
   logic clr_wr;
   logic set_wr;
   // Decoded writes to the clear and set words
   assign clr_wr = reg_wr && (reg_addr == ugsf_pkg::OFS_CLEAR);
   assign set_wr = reg_wr && (reg_addr == ugsf_pkg::OFS_SET);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Flag setting, stickiness and interrupt request
   chk_drop_sets_error: assert property (vbus_drop |=> general_status_register[3])
      else $error("vbus drop did not set error flag");
   chk_error_sticky: assert property (general_status_register[3] && !(clr_wr && reg_wdata[3]) |=> general_status_register[3])
      else $error("error flag dropped without clear write");
   chk_error_irq: assert property (vbus_error_irq_enable && general_status_register[3] ##1 general_status_register[3] |-> usb_irq)
      else $error("enabled error flag gave no interrupt");
   chk_edge_irq: assert property (vbus_edge_irq_enable && general_status_register[1] ##1 general_status_register[1] |-> usb_irq)
      else $error("enabled vbus edge flag gave no interrupt");
   chk_vbus_edge: assert property (!$past(reset) && vbus_level != $past(vbus_level) |=> general_status_register[1])
      else $error("vbus edge not flagged");
   chk_id_edge: assert property (!$past(reset) && role_id_input != $past(role_id_input) |=> general_status_register[0])
      else $error("id pin edge not flagged");
   // Clear and set words, and supply cut on error
   chk_clear_bit: assert property (clr_wr && reg_wdata[5] && !role_swap_event |=> !general_status_register[5])
      else $error("clear write left flag set");
   chk_set_bit: assert property (set_wr && reg_wdata[7] |=> general_status_register[7])
      else $error("set write did not force flag");
   chk_zero_read: assert property (reg_rd && (reg_addr == ugsf_pkg::OFS_CLEAR || reg_addr == ugsf_pkg::OFS_SET)
      |=> reg_rvalid && reg_rdata == 32'h0000_0000)
      else $error("clear or set word read nonzero");
   chk_supply_cut: assert property (vbus_drop && !vbus_output_hw_control_off && !(set_wr && reg_wdata[9])
      |=> !vbus_supply_request)
      else $error("supply request survived error under hardware control");
endmodule : ugsf_status_bank_assertions

bind ugsf_status_bank ugsf_status_bank_assertions chk_u (.clk_sys, .reset, .reg_addr, .reg_wr, .reg_rd,
   .reg_wdata, .reg_rdata, .reg_rvalid, .vbus_level, .role_id_input, .vbus_drop, .role_swap_event,
   .vbus_output_hw_control_off, .vbus_error_irq_enable, .vbus_edge_irq_enable, .usb_irq,
   .vbus_supply_request, .general_status_register);

// >>> verif/tb_ugsf_status_bank.sv
`timescale 1ns/1ps
module tb_ugsf_status_bank;
   logic [11:0] cofs [3] = '{ugsf_pkg::OFS_VERSION, ugsf_pkg::OFS_FEATURES, ugsf_pkg::OFS_ADDR_SIZE};
   logic [31:0] cexp [3] = '{32'h0005_0ABC, 32'h0000_F0F0, 32'h0000_1000};
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic vbus_level = 1'b0;
   logic role_id_input = 1'b1;
   logic vbus_drop = 1'b0;
   logic sto_ev = 1'b0;
   logic swap_ev = 1'b0;
   logic bconn_ev = 1'b0;
   logic [1:0] speed_status = 2'h0;
   logic hwc_off = 1'b1;
   logic [5:0] irq_en = 6'h00;
   logic [31:0] reg_rdata;
   logic reg_rvalid;
   logic usb_irq;
   logic supply;
   logic [31:0] gsr;
   int error_cnt = 0;
   int checks = 0;
   int cycles = 0;
   // ----------------------------------------
   // Device under test
   // ----------------------------------------
   ugsf_status_bank #(.VERSION(12'hABC), .VARIANT(4'h5), .SIZE_CODE(3'h7), .DMA_WIDE(1'b1),
      .ENDPOINTS(5'h10)) dut_u (.clk_sys, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .reg_rvalid, .vbus_level, .role_id_input, .vbus_drop, .suspend_timeout_event(sto_ev),
      .role_swap_event(swap_ev), .bconn_error_event(bconn_ev), .speed_status,
      .vbus_output_hw_control_off(hwc_off), .vbus_error_irq_enable(irq_en[0]), .vbus_edge_irq_enable(irq_en[1]),
      .idpin_edge_irq_enable(irq_en[2]), .suspend_timeout_irq_enable(irq_en[3]),
      .role_swap_irq_enable(irq_en[4]), .bconn_error_irq_enable(irq_en[5]), .usb_irq,
      .vbus_supply_request(supply), .general_status_register(gsr));
   // Clock and hang guard
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      check({31'h0, reg_rvalid}, 32'h1);
      check(reg_rdata, exp);
      tick(1);
   endtask : rd
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd(ugsf_pkg::OFS_STATUS, 32'h0000_0400);
      check(gsr, 32'h0000_0400);
      check({30'h0, usb_irq, supply}, 32'h0);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_consts();
      for (int i = 0; i < 3; i++) begin
         rd(cofs[i], cexp[i]);
         wr(cofs[i], 32'hFFFF_FFFF);
         rd(cofs[i], cexp[i]);
      end
      wr(ugsf_pkg::OFS_STATUS, 32'hFFFF_FFFF);
      wr(12'h900, 32'hFFFF_FFFF);
      rd(12'h900, 32'h0000_0000);
      check(gsr, 32'h0000_0400);
      $display("t_consts done");
   endtask : t_consts
   task automatic t_clear_set();
      wr(ugsf_pkg::OFS_SET, 32'h0000_02BB);
      check(gsr, 32'h0000_06BB);
      check({31'h0, supply}, 32'h1);
      rd(ugsf_pkg::OFS_SET, 32'h0000_0000);
      rd(ugsf_pkg::OFS_CLEAR, 32'h0000_0000);
      wr(ugsf_pkg::OFS_CLEAR, 32'h0000_0000);
      check(gsr, 32'h0000_06BB);
      wr(ugsf_pkg::OFS_CLEAR, 32'h0000_0008);
      check(gsr, 32'h0000_06B3);
      wr(ugsf_pkg::OFS_CLEAR, 32'h0000_02BB);
      check(gsr, 32'h0000_0400);
      check({31'h0, supply}, 32'h0);
      $display("t_clear_set done");
   endtask : t_clear_set
   task automatic t_events();
      speed_status = 2'h2;
      wr(ugsf_pkg::OFS_SET, 32'h0000_0200);
      vbus_drop = 1'b1;
      tick(1);
      vbus_drop = 1'b0;
      check(gsr, 32'h0000_2608);
      check({31'h0, supply}, 32'h1);
      check({31'h0, usb_irq}, 32'h0);
      irq_en = 6'h01;
      tick(2);
      check({31'h0, usb_irq}, 32'h1);
      irq_en = 6'h00;
      wr(ugsf_pkg::OFS_CLEAR, 32'h0000_0008);
      hwc_off = 1'b0;
      vbus_drop = 1'b1;
      tick(1);
      vbus_drop = 1'b0;
      check(gsr, 32'h0000_2408);
      wr(ugsf_pkg::OFS_CLEAR, 32'h0000_0008);
      vbus_level = 1'b1;
      role_id_input = 1'b0;
      tick(2);
      check(gsr, 32'h0000_2803);
      irq_en = 6'h02;
      tick(2);
      check({31'h0, usb_irq}, 32'h1);
      irq_en = 6'h04;
      wr(ugsf_pkg::OFS_CLEAR, 32'h0000_0002);
      tick(2);
      check({31'h0, usb_irq}, 32'h1);
      wr(ugsf_pkg::OFS_CLEAR, 32'h0000_0001);
      tick(2);
      check({31'h0, usb_irq}, 32'h0);
      vbus_level = 1'b0;
      role_id_input = 1'b1;
      tick(2);
      check(gsr, 32'h0000_2403);
      sto_ev = 1'b1;
      swap_ev = 1'b1;
      bconn_ev = 1'b1;
      tick(1);
      sto_ev = 1'b0;
      swap_ev = 1'b0;
      bconn_ev = 1'b0;
      check(gsr, 32'h0000_24B3);
      irq_en = 6'h38;
      wr(ugsf_pkg::OFS_CLEAR, 32'h0000_0003);
      check({31'h0, usb_irq}, 32'h1);
      wr(ugsf_pkg::OFS_CLEAR, 32'h0000_02BB);
      check(gsr, 32'h0000_2400);
      check({31'h0, usb_irq}, 32'h0);
      $display("t_events done");
   endtask : t_events
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   // Main sequence after a six-cycle reset
   initial begin
      repeat (6) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      t_reset();
      t_consts();
      t_clear_set();
      t_events();
      tally_and_finish();
   end
endmodule : tb_ugsf_status_bank
